// ===== include/essc_params.svh
// offsets, field positions, masks, command codes and timing counts of the event status block
`ifndef ESSC_PARAMS_SVH
`define ESSC_PARAMS_SVH
`define ESSC_OFF_STATUS  5'h0e
`define ESSC_OFF_AUTO    5'h1e
`define ESSC_OFF_BAD_STREAM_START_COUNT  5'h0c
`define ESSC_OFF_NEGRES  5'h05
`define ESSC_OFF_MULTI   5'h02
`define ESSC_OFF_GOODTX  5'h06
`define ESSC_OFF_HBMISS  5'h01
`define ESSC_BANK_DIAG   3'h4
`define ESSC_BANK_STATS  3'h6
`define ESSC_BIT_IRQ     0
`define ESSC_BIT_RXE     5
`define ESSC_BIT_SWEV    6
`define ESSC_BIT_HALF    7
`define ESSC_BIT_LINK    8
`define ESSC_BIT_DN      9
`define ESSC_BIT_UP      10
`define ESSC_ACK_MASK    11'h761
`define ESSC_SRC_MASK    11'h7fe
`define ESSC_OP_GRST     5'h00
`define ESSC_OP_SELBANK  5'h01
`define ESSC_OP_REQIRQ   5'h0c
`define ESSC_OP_ACK      5'h0d
`define ESSC_OP_SETIE    5'h0e
`define ESSC_OP_SETIND   5'h0f
`define ESSC_OP_STATS_EN 5'h15
`define ESSC_OP_STATS_DI 5'h16
`define ESSC_CNT_HALF    8'h80
`define ESSC_CLK_NS      10
`define ESSC_GRST_NS     40
`define ESSC_GRST_CYC    ((`ESSC_GRST_NS + `ESSC_CLK_NS - 1) / `ESSC_CLK_NS)
`endif

// ===== include/essc_pkg.sv
// types shared by the event status block
package essc_pkg;
  typedef logic [15:0] essc_word_type;
  typedef logic [10:0] essc_flag_type;
  typedef logic [2:0]  essc_bank_type;
endpackage

// ===== design/essc_top.sv
// event status flags, self-acknowledging view and statistics counters
`timescale 1ns/100ps
`include "essc_params.svh"
// What this block does
// - link change sets flag bit 8
// - negotiation result read clears link flag
// - self-ack read or ack command clears link
// - link flag raised regardless of transceiver choice
// - notified download done sets bit 9
// - upload done sets bit 10
// - bit 12 high while command executes
// - bits 15:13 show bank, reset zero
// - self-ack view at 1e mirrors status
// - self-ack read clears interrupt enables
// - self-ack read clears acknowledgeable flags
// - counters advance once collection enabled
// - counter read returns value and clears
// - counter write adds to contents
// - counter reaching half sets half-full flag
// - half-full clears after all counters read
// - carrier loss, heartbeat are not errors
// - multi-collision counts 2..15 collisions, good
// - bad stream start counter, bank 4
// - bad stream counter wraps, half at 80h
// - flags set only when indication enabled
// - line state is OR of enabled sources
module essc_top
  import essc_pkg::*;
#(
  parameter int NUM_CNT  = 4,
  parameter int CNT_W    = 8,
  parameter int GRST_CYC = `ESSC_GRST_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [4:0]    io_addr,
  input  wire logic          io_rd,
  input  wire logic          io_wr,
  input  wire essc_word_type io_wdata,
  input  wire logic          link_good,
  input  wire logic          dn_done,
  input  wire logic          dn_notify,
  input  wire logic          up_done,
  input  wire logic          rx_early,
  input  wire logic          tx_done,
  input  wire logic          tx_fatal_err,
  input  wire logic          hb_missing,
  input  wire logic [3:0]    tx_coll,
  input  wire logic          bad_ssd,
  input  wire logic          mode_100tx,
  output essc_word_type      io_rdata,
  output logic               irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  essc_word_type            io_rdata_r, io_rdata_nxt;
  logic                     irq_r, irq_nxt;
  essc_flag_type            flags_r, flags_nxt, ie_r, ie_nxt, ind_r, ind_nxt;
  essc_bank_type            bank_r, bank_nxt;
  logic                     stats_r, stats_nxt, link_q_r;
  logic [7:0]               pend_cnt_r, pend_cnt_nxt;
  logic [NUM_CNT-1:0]       seen_r, seen_nxt, inc, cnt_acc;
  logic [CNT_W-1:0]         cnt_r [NUM_CNT];
  logic [CNT_W-1:0]         cnt_nxt [NUM_CNT];
  logic [CNT_W-1:0]         base, sum_bad;
  essc_flag_type            set, clr;
  logic                     grst_now, rd_auto, half_set;
  int                       rd_idx;

  // counter slot seen at an address in the visible bank, NUM_CNT if none
  function automatic int cnt_idx(input essc_bank_type bk, input logic [4:0] a);
    cnt_idx = NUM_CNT;
    if (bk == `ESSC_BANK_DIAG && a == `ESSC_OFF_BAD_STREAM_START_COUNT) cnt_idx = 0;
    if (bk == `ESSC_BANK_STATS && a == `ESSC_OFF_MULTI) cnt_idx = 1;
    if (bk == `ESSC_BANK_STATS && a == `ESSC_OFF_GOODTX) cnt_idx = 2;
    if (bk == `ESSC_BANK_STATS && a == `ESSC_OFF_HBMISS) cnt_idx = 3;
  endfunction

  // masked flags read as zero even if set before the mask was dropped
  // view layout
  function automatic essc_word_type view();
    essc_flag_type f;
    f = flags_r & ind_r;
    view = {bank_r, (pend_cnt_r != 8'h00), 1'b0, f[10:5], 4'h0, irq_r};
  endfunction

  assign rd_idx   = cnt_idx(bank_r, io_addr);
  assign rd_auto  = io_rd && io_addr == `ESSC_OFF_AUTO;
  // commands arriving while one is pending are dropped
  assign grst_now = io_wr && io_addr == `ESSC_OFF_STATUS && pend_cnt_r == 8'h00
                    && io_wdata[15:11] == `ESSC_OP_GRST;
  assign sum_bad  = cnt_r[0] + io_wdata[CNT_W-1:0];

  // ----------------------------------------
  // counter events
  // ----------------------------------------
  always_comb begin
    inc = '0;
    inc[0] = stats_r && bad_ssd && mode_100tx;
    inc[1] = stats_r && tx_done && !tx_fatal_err && tx_coll >= 4'h2;
    inc[2] = stats_r && tx_done && !tx_fatal_err;
    inc[3] = stats_r && tx_done && hb_missing;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    bank_nxt     = bank_r;
    ie_nxt       = ie_r;
    ind_nxt      = ind_r;
    stats_nxt    = stats_r;
    seen_nxt     = seen_r;
    io_rdata_nxt = io_rdata_r;
    pend_cnt_nxt = (pend_cnt_r != 8'h00) ? pend_cnt_r - 8'h01 : pend_cnt_r;
    set          = '0;
    clr          = '0;
    half_set     = 1'b0;
    cnt_acc      = '0;
    base         = '0;
    // entry or exit of link good
    set[`ESSC_BIT_LINK] = link_good ^ link_q_r;
    set[`ESSC_BIT_DN]   = dn_done && dn_notify;
    set[`ESSC_BIT_UP]   = up_done;
    set[`ESSC_BIT_RXE]  = rx_early;
    if (io_rd || io_wr) begin
      for (int i = 0; i < NUM_CNT; i++) cnt_acc[i] = (rd_idx == i);
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      base = cnt_r[i];
      if (cnt_acc[i] && io_rd) base = '0;
      if (cnt_acc[i] && io_wr) base = cnt_r[i] + io_wdata[CNT_W-1:0];
      cnt_nxt[i] = base + CNT_W'(inc[i]);
      if (!base[CNT_W-1] && cnt_nxt[i][CNT_W-1]) half_set = 1'b1;
    end
    set[`ESSC_BIT_HALF] = half_set;
    if (io_rd) begin
      io_rdata_nxt = '0;
      if (io_addr == `ESSC_OFF_STATUS || rd_auto) io_rdata_nxt = view();
      if (rd_auto) begin
        ie_nxt = '0;
        clr = clr | `ESSC_ACK_MASK;
      end
      if (bank_r == `ESSC_BANK_DIAG && io_addr == `ESSC_OFF_NEGRES) begin
        io_rdata_nxt = {15'h0000, link_q_r};
        clr[`ESSC_BIT_LINK] = 1'b1;
      end
      if (rd_idx < NUM_CNT) begin
        io_rdata_nxt = {{(16 - CNT_W){1'b0}}, cnt_r[rd_idx]};
        seen_nxt[rd_idx] = 1'b1;
      end
    end
    if (&seen_nxt) begin
      seen_nxt = '0;
      clr[`ESSC_BIT_HALF] = 1'b1;
    end
    if (io_wr && io_addr == `ESSC_OFF_STATUS && pend_cnt_r == 8'h00) begin
      unique case (io_wdata[15:11])
        `ESSC_OP_SELBANK:  bank_nxt = io_wdata[2:0];
        `ESSC_OP_REQIRQ:   set[`ESSC_BIT_SWEV] = 1'b1;
        `ESSC_OP_ACK:      clr = clr | (io_wdata[10:0] & `ESSC_ACK_MASK);
        `ESSC_OP_SETIE:    ie_nxt = io_wdata[10:0];
        `ESSC_OP_SETIND:   ind_nxt = io_wdata[10:0];
        `ESSC_OP_STATS_EN: stats_nxt = 1'b1;
        `ESSC_OP_STATS_DI: stats_nxt = 1'b0;
        // global reset is the multi-cycle command
        `ESSC_OP_GRST:     pend_cnt_nxt = 8'(GRST_CYC);
        default:           ;
      endcase
    end
    // set gated by indication; set wins over clear
    flags_nxt = (flags_r & ~clr) | (set & ind_r);
    if (grst_now) begin
      bank_nxt  = '0;
      flags_nxt = '0;
      ie_nxt    = '0;
      ind_nxt   = '0;
      stats_nxt = 1'b0;
      seen_nxt  = '0;
      for (int i = 0; i < NUM_CNT; i++) cnt_nxt[i] = '0;
    end
    irq_nxt = |(flags_nxt & ind_nxt & ie_nxt & `ESSC_SRC_MASK);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata_r <= '0;
      irq_r      <= 1'b0;
      flags_r    <= '0;
      ie_r       <= '0;
      ind_r      <= '0;
      bank_r     <= '0;
      stats_r    <= 1'b0;
      link_q_r   <= 1'b0;
      pend_cnt_r <= '0;
      seen_r     <= '0;
      for (int i = 0; i < NUM_CNT; i++) cnt_r[i] <= '0;
    end else begin
      io_rdata_r <= io_rdata_nxt;
      irq_r      <= irq_nxt;
      flags_r    <= flags_nxt;
      ie_r       <= ie_nxt;
      ind_r      <= ind_nxt;
      bank_r     <= bank_nxt;
      stats_r    <= stats_nxt;
      link_q_r   <= link_good;
      pend_cnt_r <= pend_cnt_nxt;
      seen_r     <= seen_nxt;
      for (int i = 0; i < NUM_CNT; i++) cnt_r[i] <= cnt_nxt[i];
    end
  end

  assign io_rdata = io_rdata_r;
  assign irq      = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_busy;
    (pend_cnt_r != 8'h00) [*4];
  endsequence

  property p_link_set;
    (link_good ^ link_q_r) && ind_r[`ESSC_BIT_LINK] && !grst_now |=> flags_r[`ESSC_BIT_LINK];
  endproperty
  a_link_set: assert property (p_link_set) else $error("link change not flagged");

  property p_auto_ie;
    rd_auto && !grst_now |=> ie_r == '0 && !irq_r;
  endproperty
  a_auto_ie: assert property (p_auto_ie) else $error("self-ack read left enables");

  property p_auto_dn;
    rd_auto && !(dn_done && dn_notify) |=> !flags_r[`ESSC_BIT_DN];
  endproperty
  a_auto_dn: assert property (p_auto_dn) else $error("self-ack read kept download flag");

  property p_pend;
    grst_now |=> s_busy ##1 (pend_cnt_r == 8'h00);
  endproperty
  a_pend: assert property (p_pend) else $error("pending flag length wrong");

  property p_bank;
    grst_now |=> bank_r == '0;
  endproperty
  a_bank: assert property (p_bank) else $error("bank not reset by global reset");

  property p_rd_clr;
    io_rd && cnt_acc[0] && !inc[0] && !grst_now |=> cnt_r[0] == '0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("counter not cleared by read");

  property p_wr_add;
    io_wr && cnt_acc[0] && !inc[0] |=> cnt_r[0] == $past(sum_bad);
  endproperty
  a_wr_add: assert property (p_wr_add) else $error("counter write did not add");

  property p_half;
    cnt_r[0] == 8'h7f && inc[0] && !cnt_acc[0] && ind_r[`ESSC_BIT_HALF] && !grst_now
      |=> flags_r[`ESSC_BIT_HALF];
  endproperty
  a_half: assert property (p_half) else $error("half-full not raised at 80h");

  property p_multi;
    tx_done && tx_coll == 4'h1 && !cnt_acc[1] && !grst_now |=> $stable(cnt_r[1]);
  endproperty
  a_multi: assert property (p_multi) else $error("single collision counted as multiple");

  property p_irq;
    (flags_r & ind_r & ie_r & `ESSC_SRC_MASK) != '0 |-> irq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("line state missing enabled source");
endmodule

// ===== verification/essc_host_model.sv
// host driver model making single register reads and writes
`timescale 1ns/100ps
module essc_host_model
  import essc_pkg::*;
#(
  parameter int GRST_CYC = 4
) (
  input  wire logic     clk,
  output logic [4:0]    io_addr,
  output logic          io_rd,
  output logic          io_wr,
  output essc_word_type io_wdata
);
  initial begin
    io_addr = 5'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 16'h0000;
  end
  task automatic io_read(input logic [4:0] a);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    io_addr = ~a;
  endtask
  task automatic io_write(input logic [4:0] a, input essc_word_type d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  task automatic settle();
    repeat (GRST_CYC + 2) @(negedge clk);
  endtask
endmodule

// ===== verification/essc_tb_top.sv
// self-checking bench for the event status and statistics block
`timescale 1ns/100ps
`include "essc_params.svh"
module event_status_and_stats_counters_tb_top
  import essc_pkg::*;
  ;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [4:0]    io_addr;
  logic          io_rd, io_wr, irq, rd_q = 1'b0;
  essc_word_type io_wdata, io_rdata;
  logic          link_good, dn_done, dn_notify, up_done, rx_early, tx_done;
  logic          tx_fatal_err, hb_missing, bad_ssd, mode_100tx;
  logic [3:0]    tx_coll;
  int            mismatches = 0, checked = 0, cyc = 0, i, ngood = 0, nmul = 0, nhb = 0;
  logic [7:0]    v, w;
  essc_word_type expq[$];
  essc_flag_type flg = '0, ie = '0;
  essc_bank_type bank = '0;
  always #5 clk = ~clk;
  essc_host_model #(.GRST_CYC(4)) host_u (.clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata));
  essc_top #(.GRST_CYC(4)) dut_u (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .link_good(link_good), .dn_done(dn_done), .dn_notify(dn_notify),
    .up_done(up_done), .rx_early(rx_early), .tx_done(tx_done), .tx_fatal_err(tx_fatal_err),
    .hb_missing(hb_missing), .tx_coll(tx_coll), .bad_ssd(bad_ssd), .mode_100tx(mode_100tx),
    .io_rdata(io_rdata), .irq(irq));
  task automatic chk16(input string nm, input essc_word_type e, input essc_word_type g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    // a read whose data never came back is a mismatch too
    if (expq.size() != 0) mismatches++;
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic essc_word_type st(input logic pend);
    return {bank, pend, 1'b0, flg[10:1], |(flg & ie & `ESSC_SRC_MASK)};
  endfunction
  task automatic rd(input logic [4:0] a, input essc_word_type e);
    expq.push_back(e);
    host_u.io_read(a);
  endtask
  task automatic cmd(input logic [4:0] op, input logic [10:0] arg);
    host_u.io_write(`ESSC_OFF_STATUS, {op, arg});
  endtask
  task automatic ev(input logic [3:0] m);
    @(negedge clk);
    {bad_ssd, rx_early, up_done, dn_done} = m;
    @(negedge clk);
    {bad_ssd, rx_early, up_done, dn_done} = 4'h0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk);
    chk16("irq", {15'h0000, e}, {15'h0000, irq});
  endtask
  // read data lands one cycle after the strobe
  always @(posedge clk) begin
    if (rd_q && expq.size() > 0) chk16("io_rdata", expq.pop_front(), io_rdata);
    rd_q <= io_rd;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {link_good, dn_done, dn_notify, up_done, rx_early, tx_done, tx_fatal_err, hb_missing, bad_ssd} = '0;
    tx_coll = 4'h0;
    mode_100tx = 1'b1;
    v = 8'($urandom(37806));
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    rd(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h0000);
    cmd(`ESSC_OP_SETIND, 11'h7ff);
    cmd(`ESSC_OP_SETIE, 11'h100);
    ie = 11'h100;
    @(negedge clk);
    link_good = 1'b1;
    flg[8] = 1'b1;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    chk_irq(1'b1);
    cmd(`ESSC_OP_SELBANK, 11'h004);
    bank = 3'h4;
    rd(`ESSC_OFF_NEGRES, 16'h0001);
    flg[8] = 1'b0;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    @(negedge clk);
    link_good = 1'b0;
    flg[8] = 1'b1;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    cmd(`ESSC_OP_ACK, 11'h100);
    flg[8] = 1'b0;
    dn_notify = 1'b1;
    ev(4'h7);
    flg[10:9] = 2'b11;
    flg[5] = 1'b1;
    cmd(`ESSC_OP_REQIRQ, 11'h000);
    flg[6] = 1'b1;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    dn_notify = 1'b0;
    cmd(`ESSC_OP_ACK, 11'h200);
    flg[9] = 1'b0;
    ev(4'h1);
    cmd(`ESSC_OP_SETIE, 11'h7fe);
    ie = 11'h7fe;
    host_u.io_write(`ESSC_OFF_AUTO, 16'hffff);
    rd(`ESSC_OFF_STATUS, st(1'b0));
    rd(`ESSC_OFF_AUTO, st(1'b0));
    flg = flg & ~`ESSC_ACK_MASK;
    ie = '0;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    chk_irq(1'b0);
    cmd(`ESSC_OP_SETIND, 11'h3ff);
    ev(4'h2);
    rd(`ESSC_OFF_STATUS, st(1'b0));
    cmd(`ESSC_OP_SETIND, 11'h7ff);
    ev(4'h8);
    cmd(`ESSC_OP_STATS_EN, 11'h000);
    mode_100tx = 1'b0;
    ev(4'h8);
    mode_100tx = 1'b1;
    for (i = 0; i < 3; i++) ev(4'h8);
    rd(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h0003);
    rd(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h0000);
    // events while collection is off must not count
    cmd(`ESSC_OP_STATS_DI, 11'h000);
    ev(4'h8);
    cmd(`ESSC_OP_STATS_EN, 11'h000);
    v = 8'($urandom) & 8'h3f;
    w = 8'($urandom) & 8'h3f;
    host_u.io_write(`ESSC_OFF_BAD_STREAM_START_COUNT, {8'h00, v});
    host_u.io_write(`ESSC_OFF_BAD_STREAM_START_COUNT, {8'h00, w});
    rd(`ESSC_OFF_BAD_STREAM_START_COUNT, {8'h00, v + w});
    host_u.io_write(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h007f);
    ev(4'h8);
    flg[7] = 1'b1;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    host_u.io_write(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h007f);
    ev(4'h8);
    rd(`ESSC_OFF_BAD_STREAM_START_COUNT, 16'h0000);
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      {tx_fatal_err, hb_missing, tx_coll} = 6'($urandom);
      // one good frame with a single collision is always sent
      if (i == 0) {tx_fatal_err, tx_coll} = 5'h01;
      tx_done = 1'b1;
      ngood += !tx_fatal_err;
      nmul += (!tx_fatal_err && tx_coll >= 4'h2);
      nhb += hb_missing;
      @(negedge clk);
      tx_done = 1'b0;
    end
    cmd(`ESSC_OP_SELBANK, 11'h006);
    bank = 3'h6;
    rd(`ESSC_OFF_MULTI, 16'(nmul));
    rd(`ESSC_OFF_GOODTX, 16'(ngood));
    rd(`ESSC_OFF_HBMISS, 16'(nhb));
    flg[7] = 1'b0;
    rd(`ESSC_OFF_STATUS, st(1'b0));
    cmd(`ESSC_OP_GRST, 11'h000);
    bank = '0;
    flg = '0;
    rd(`ESSC_OFF_STATUS, st(1'b1));
    host_u.settle();
    rd(`ESSC_OFF_STATUS, st(1'b0));
    repeat (3) @(negedge clk);
    give_verdict();
  end
endmodule
